// File: rtl/ppc_cfg.svh
// Overview of operation
// - Port 0: two pins, direction, pull-up option
// - Port 1: eight pins, direction, pull-ups
// - Port 2: five pins, direction, analog inputs
// - Port 2 pins start in analog mode
// - Port 3: four pins, direction, pull-ups
// - Port 6: two pins, direction, I2C lines
// - Port 6 only pulls low, never high
// - Port 7: one pin, direction, pull-up
// - Each pin selects port or control mode
// - External interrupt edges: rising, falling or both; key interrupt on falling edge only
// - First port 0 pin: timer clock, capture
// - Second port 0 pin: capture or timer out
// - Port 1 routes serial, UART, timer, interrupt
// - Port 3 routes interrupts, timer 8b clock/out
// - Port 7 pin is key interrupt
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PPC_OFS_OUT    12'h000
`define PPC_OFS_DIR    12'h004
`define PPC_OFS_PULL   12'h008
`define PPC_OFS_CTRL   12'h00c
`define PPC_OFS_PIN    12'h010
`define PPC_OFS_RISE   12'h014
`define PPC_OFS_FALL   12'h018
// ----------------------------------------
// Reset values and masks, 22 pin bits
// ----------------------------------------
`define PPC_RST_OUT    22'h000000
`define PPC_RST_DIR    22'h3fffff
`define PPC_RST_PULL   22'h000000
`define PPC_RST_CTRL   22'h007c00
`define PPC_PULL_MASK  22'h2783ff
`define PPC_RST_EDGE   5'h00
// ----------------------------------------
// Pin positions in the packed vector
// ----------------------------------------
`define PPC_P00 0
`define PPC_P01 1
`define PPC_P10 2
`define PPC_P11 3
`define PPC_P12 4
`define PPC_P13 5
`define PPC_P14 6
`define PPC_P15 7
`define PPC_P16 8
`define PPC_P17 9
`define PPC_P2LO 10
`define PPC_P2HI 14
`define PPC_P30 15
`define PPC_P33 18
`define PPC_P60 19
`define PPC_P61 20
`define PPC_P70 21
`endif

// File: rtl/ppc_pkg.sv
package ppc_pkg;
  // Outputs offered by the peripheral units, each with its drive request; the I2C lines carry only a pull-low request
  typedef struct packed {
    logic timer16Out;
    logic timer16OutEn;
    logic csiClockOut;
    logic csiClockOe;
    logic uart0Tx;
    logic uart0TxEn;
    logic csiDataOut;
    logic csiDataOe;
    logic uart6Tx;
    logic uart6TxEn;
    logic timerH0;
    logic timerH0En;
    logic timerH1;
    logic timerH1En;
    logic timer8aOut;
    logic timer8aOutEn;
    logic timer8bOut;
    logic timer8bOutEn;
    logic i2cSclLow;
    logic i2cSdaLow;
  } ppc_alt_out_t;
  // Pin levels handed to the peripheral units, plus the port 2 analog enables
  typedef struct packed {
    logic       timer16ClockCaptureIn;
    logic       timer16CaptureIn;
    logic       csiClockIn;
    logic       csiDataIn;
    logic       uart0Rx;
    logic       uart6Rx;
    logic       timer8aClockIn;
    logic       timer8bClockIn;
    logic       i2cSclIn;
    logic       i2cSdaIn;
    logic       keyIrqInput;
    logic [4:0] analogInputs;
  } ppc_alt_in_t;
endpackage

// File: rtl/port_pin_control.sv
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "ppc_cfg.svh"
module port_pin_control
  import ppc_pkg::*;
#(
  parameter int NPINS = 22
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [NPINS-1:0]   pinIn,
  output logic      [NPINS-1:0]   pinOut,
  output logic      [NPINS-1:0]   pinOe_n,
  output logic      [NPINS-1:0]   pullupOn,
  output logic      [4:0]         analogEnable,
  input  wire ppc_alt_out_t       altOut,
  output ppc_alt_in_t             altIn,
  output logic      [4:0]         extIrqInputs,
  output logic                    keyIrqEdge
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [NPINS-1:0] outReg;
  logic [NPINS-1:0] dirReg;
  logic [NPINS-1:0] pullReg;
  logic [NPINS-1:0] ctrlReg;
  logic [NPINS-1:0] pinReg;
  logic [NPINS-1:0] pinPrevReg;
  logic [4:0]       riseReg;
  logic [4:0]       fallReg;
  logic             ackReg;
  logic             apbDone;
  logic             apbWrite;
  logic             hit;
  logic [31:0]      rdNext;
  logic [4:0]       irqCur;
  logic [4:0]       irqPrev;
  logic [4:0]       irqCtl;
  logic [NPINS-1:0] altVal;
  logic [NPINS-1:0] altDrv;

  // ----------------------------------------
  // APB slave: one wait state so read data comes from a flop
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) ackReg <= 1'b0;
    else ackReg <= psel & penable & ~ackReg;
  end

  assign pready   = psel & penable & ackReg;
  assign apbDone  = pready;
  assign apbWrite = apbDone & pwrite & ~pslverr;

  // Address decode; anything off the map answers with an error
  always_comb begin
    hit    = 1'b1;
    rdNext = 32'h0000_0000;
    case (paddr)
      `PPC_OFS_OUT:  rdNext[NPINS-1:0] = outReg;
      `PPC_OFS_DIR:  rdNext[NPINS-1:0] = dirReg;
      `PPC_OFS_PULL: rdNext[NPINS-1:0] = pullReg;
      `PPC_OFS_CTRL: rdNext[NPINS-1:0] = ctrlReg;
      `PPC_OFS_PIN:  rdNext[NPINS-1:0] = pinReg;
      `PPC_OFS_RISE: rdNext[4:0] = riseReg;
      `PPC_OFS_FALL: rdNext[4:0] = fallReg;
      default:       hit = 1'b0;
    endcase
  end

  assign pslverr = pready & ~hit;

  // Read data captured in the first access cycle, held for the answer
  always_ff @(posedge clock) begin
    if (rst) prdata <= 32'h0000_0000;
    else if (psel & penable & ~ackReg & ~pwrite) prdata <= rdNext;
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Output latches and direction; reset leaves every pin an input
  always_ff @(posedge clock) begin
    if (rst) begin
      outReg <= `PPC_RST_OUT;
      dirReg <= `PPC_RST_DIR;
    end else if (apbWrite) begin
      if (paddr == `PPC_OFS_OUT) outReg <= pwdata[NPINS-1:0];
      if (paddr == `PPC_OFS_DIR) dirReg <= pwdata[NPINS-1:0];
    end
  end

  // Pull-ups exist only on ports 0, 1, 3 and 7; other bits stay zero
  always_ff @(posedge clock) begin
    if (rst) pullReg <= `PPC_RST_PULL;
    else if (apbWrite && paddr == `PPC_OFS_PULL)
      pullReg <= pwdata[NPINS-1:0] & `PPC_PULL_MASK;
  end

  // Control mode select; port 2 comes up in analog mode
  always_ff @(posedge clock) begin
    if (rst) ctrlReg <= `PPC_RST_CTRL;
    else if (apbWrite && paddr == `PPC_OFS_CTRL)
      ctrlReg <= pwdata[NPINS-1:0];
  end

  // Edge selection per interrupt input, both bits set gives both edges
  always_ff @(posedge clock) begin
    if (rst) begin
      riseReg <= `PPC_RST_EDGE;
      fallReg <= `PPC_RST_EDGE;
    end else if (apbWrite) begin
      if (paddr == `PPC_OFS_RISE) riseReg <= pwdata[4:0];
      if (paddr == `PPC_OFS_FALL) fallReg <= pwdata[4:0];
    end
  end

  // ----------------------------------------
  // Pin sampling
  // ----------------------------------------
  // Pins are synchronous; two register stages give a clean history
  always_ff @(posedge clock) begin
    if (rst) begin
      pinReg     <= '0;
      pinPrevReg <= '0;
    end else begin
      pinReg     <= pinIn;
      pinPrevReg <= pinReg;
    end
  end

  // ----------------------------------------
  // Alternate output routing
  // ----------------------------------------
  // Serial clock has priority over UART0 transmit on the shared pin
  always_comb begin
    altVal = '0;
    altDrv = '0;
    altVal[`PPC_P01] = altOut.timer16Out;
    altDrv[`PPC_P01] = altOut.timer16OutEn;
    altVal[`PPC_P10] = altOut.csiClockOe ? altOut.csiClockOut : altOut.uart0Tx;
    altDrv[`PPC_P10] = altOut.csiClockOe | altOut.uart0TxEn;
    altVal[`PPC_P12] = altOut.csiDataOut;
    altDrv[`PPC_P12] = altOut.csiDataOe;
    altVal[`PPC_P13] = altOut.uart6Tx;
    altDrv[`PPC_P13] = altOut.uart6TxEn;
    altVal[`PPC_P15] = altOut.timerH0;
    altDrv[`PPC_P15] = altOut.timerH0En;
    altVal[`PPC_P16] = altOut.timerH1;
    altDrv[`PPC_P16] = altOut.timerH1En;
    altVal[`PPC_P17] = altOut.timer8aOut;
    altDrv[`PPC_P17] = altOut.timer8aOutEn;
    altVal[`PPC_P33] = altOut.timer8bOut;
    altDrv[`PPC_P33] = altOut.timer8bOutEn;
    altDrv[`PPC_P60] = altOut.i2cSclLow;
    altDrv[`PPC_P61] = altOut.i2cSdaLow;
  end

  // ----------------------------------------
  // Pad drivers, one per pin
  // ----------------------------------------
  // Analog pins never drive; port 6 only sinks current
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pad
      logic drv;
      logic val;
      always_comb begin
        if (ctrlReg[gi]) begin
          drv = altDrv[gi];
          val = altVal[gi];
        end else begin
          drv = ~dirReg[gi];
          val = outReg[gi];
        end
      end
      if (gi == `PPC_P60 || gi == `PPC_P61) begin : g_od
        // Drive only a low level; a one releases the line
        assign pinOut[gi]  = 1'b0;
        assign pinOe_n[gi] = ~(drv & (ctrlReg[gi] | ~val));
      end else if (gi >= `PPC_P2LO && gi <= `PPC_P2HI) begin : g_an
        assign pinOut[gi]  = val;
        assign pinOe_n[gi] = ~(drv & ~ctrlReg[gi]);
      end else begin : g_pp
        assign pinOut[gi]  = val;
        assign pinOe_n[gi] = ~drv;
      end
      // Pull-up is off whenever the pin drives
      assign pullupOn[gi] = pullReg[gi] & ~drv;
    end
  endgenerate

  assign analogEnable = ctrlReg[`PPC_P2HI:`PPC_P2LO];

  // ----------------------------------------
  // Alternate input routing
  // ----------------------------------------
  always_comb begin
    altIn = '0;
    altIn.timer16ClockCaptureIn = pinReg[`PPC_P00] & ctrlReg[`PPC_P00];
    altIn.timer16CaptureIn = pinReg[`PPC_P01] & ctrlReg[`PPC_P01];
    altIn.csiClockIn       = pinReg[`PPC_P10] & ctrlReg[`PPC_P10];
    altIn.csiDataIn        = pinReg[`PPC_P11] & ctrlReg[`PPC_P11];
    altIn.uart0Rx          = pinReg[`PPC_P11] | ~ctrlReg[`PPC_P11];
    altIn.uart6Rx          = pinReg[`PPC_P14] | ~ctrlReg[`PPC_P14];
    altIn.timer8aClockIn   = pinReg[`PPC_P17] & ctrlReg[`PPC_P17];
    altIn.timer8bClockIn   = pinReg[`PPC_P33] & ctrlReg[`PPC_P33];
    altIn.i2cSclIn         = pinReg[`PPC_P60] | ~ctrlReg[`PPC_P60];
    altIn.i2cSdaIn         = pinReg[`PPC_P61] | ~ctrlReg[`PPC_P61];
    altIn.keyIrqInput      = pinReg[`PPC_P70] & ctrlReg[`PPC_P70];
    altIn.analogInputs     = analogEnable;
  end

  // ----------------------------------------
  // External interrupt edge detection
  // ----------------------------------------
  // Index 0..3 are port 3 pins, index 4 is the port 1 pin
  assign irqCur  = {pinReg[`PPC_P16], pinReg[`PPC_P33:`PPC_P30]};
  assign irqPrev = {pinPrevReg[`PPC_P16], pinPrevReg[`PPC_P33:`PPC_P30]};
  assign irqCtl  = {ctrlReg[`PPC_P16], ctrlReg[`PPC_P33:`PPC_P30]};

  // Registered one-cycle pulses; a pin in port mode raises nothing
  always_ff @(posedge clock) begin
    if (rst) begin
      extIrqInputs <= 5'h00;
      keyIrqEdge   <= 1'b0;
    end else begin
      extIrqInputs <= irqCtl & ((riseReg & irqCur & ~irqPrev) |
                                (fallReg & ~irqCur & irqPrev));
      keyIrqEdge   <= ctrlReg[`PPC_P70] & ~pinReg[`PPC_P70]
                      & pinPrevReg[`PPC_P70];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_ANALOG_RESET: assert property (@(posedge clock)
    rst |=> analogEnable == 5'h1f && pinOe_n[`PPC_P2HI:`PPC_P2LO] == 5'h1f)
    else $error("Port 2 not analog after reset");

  AST_INPUT_RESET: assert property (@(posedge clock)
    rst |=> (&pinOe_n) && pullupOn == '0)
    else $error("Pin driving or pulled after reset");

  AST_OPEN_DRAIN: assert property (@(posedge clock) disable iff (rst)
    pinOut[`PPC_P61:`PPC_P60] == 2'b00)
    else $error("Port 6 driven high");

  AST_NO_PULL_P26: assert property (@(posedge clock) disable iff (rst)
    pullupOn[`PPC_P2HI:`PPC_P2LO] == 5'h00 && pullupOn[`PPC_P61:`PPC_P60] == 2'b00)
    else $error("Pull-up on port without option");

  AST_PORT_DRIVE: assert property (@(posedge clock) disable iff (rst)
    !ctrlReg[`PPC_P17] && !dirReg[`PPC_P17]
      |-> !pinOe_n[`PPC_P17] && pinOut[`PPC_P17] == outReg[`PPC_P17])
    else $error("Port mode output wrong");

  AST_RISE_EDGE: assert property (@(posedge clock) disable iff (rst)
    ctrlReg[`PPC_P30] && riseReg[0] && $rose(pinReg[`PPC_P30])
      |=> extIrqInputs[0])
    else $error("Rising edge missed");

  AST_FALL_ONLY: assert property (@(posedge clock) disable iff (rst)
    !fallReg[4] && $fell(pinReg[`PPC_P16]) |=> !extIrqInputs[4])
    else $error("Falling edge taken when disabled");

  AST_TIMER16_IN: assert property (@(posedge clock) disable iff (rst)
    ctrlReg[`PPC_P00] |-> altIn.timer16ClockCaptureIn == pinReg[`PPC_P00])
    else $error("Timer clock input not routed");

  AST_APB_WAIT: assert property (@(posedge clock) disable iff (rst)
    psel && penable && !ackReg |-> !pready ##1 (psel && penable) |-> pready)
    else $error("APB answer timing wrong");

  AST_KEY_EDGE: assert property (@(posedge clock) disable iff (rst)
    ctrlReg[`PPC_P70] && $fell(pinReg[`PPC_P70]) |=> keyIrqEdge)
    else $error("Key falling edge missed");

  AST_ANALOG_NO_DRIVE: assert property (@(posedge clock) disable iff (rst)
    (analogEnable & ~pinOe_n[`PPC_P2HI:`PPC_P2LO]) == 5'h00)
    else $error("Analog pin driven");

  AST_I2C_SINK: assert property (@(posedge clock) disable iff (rst)
    ctrlReg[`PPC_P60] && altOut.i2cSclLow |-> !pinOe_n[`PPC_P60])
    else $error("Clock line not pulled low");

  AST_IRQ_PORT_MODE: assert property (@(posedge clock) disable iff (rst)
    !ctrlReg[`PPC_P30] |=> !extIrqInputs[0])
    else $error("Event raised in port mode");

  AST_TIMER16_OUT: assert property (@(posedge clock) disable iff (rst)
    ctrlReg[`PPC_P01] && altOut.timer16OutEn
      |-> !pinOe_n[`PPC_P01] && pinOut[`PPC_P01] == altOut.timer16Out)
    else $error("Timer output not routed");
endmodule // port_pin_control
`default_nettype wire

// File: sim/ppc_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module ppc_pin_model (
  input  wire logic        clock,
  input  wire logic [21:0] pinOut,
  input  wire logic [21:0] pinOe_n,
  input  wire logic [21:0] pullupOn,
  input  wire logic [21:0] extEn,
  input  wire logic [21:0] extVal,
  output logic      [21:0] pinLevel
);
  // Floating pins wander so a stale level never passes for a real one
  logic wander_reg = 1'b0;
  always_ff @(posedge clock) begin
    wander_reg <= ~wander_reg;
  end
  // Device drive first, then outside drivers, then pull-ups
  always_comb begin
    for (int i = 0; i < 22; i++) begin
      if (!pinOe_n[i]) begin
        pinLevel[i] = pinOut[i];
      end else if (extEn[i]) begin
        pinLevel[i] = extVal[i];
      end else if (pullupOn[i] || i == 19 || i == 20) begin
        pinLevel[i] = 1'b1;
      end else begin
        pinLevel[i] = wander_reg;
      end
    end
  end
endmodule // ppc_pin_model
`default_nettype wire

// File: sim/tb_port_pin_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "ppc_cfg.svh"
`define CHK(A, B) begin checks++; if ((A) !== (B)) begin failures++; \
  $display("BAD %0t got %h exp %h", $time, A, B); end end
module tb_port_pin_control;
  import ppc_pkg::*;
  logic         clock = 1'b0;
  logic         rst = 1'b1;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata, rd, v;
  logic         pready, pslverr, err, keyIrqEdge;
  logic [21:0]  pinLevel, pinOut, pinOe_n, pullupOn, o, e, d;
  logic [21:0]  extEn = 22'h0;
  logic [21:0]  extVal = 22'h0;
  logic [4:0]   analogEnable, extIrqInputs;
  ppc_alt_out_t altOut = '0;
  ppc_alt_in_t  altIn;
  int           failures = 0;
  int           checks = 0;
  int           cycles = 0;
  int           seed;
  integer       cnt[6];

  port_pin_control uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinIn(pinLevel), .pinOut(pinOut), .pinOe_n(pinOe_n),
    .pullupOn(pullupOn), .analogEnable(analogEnable), .altOut(altOut), .altIn(altIn),
    .extIrqInputs(extIrqInputs), .keyIrqEdge(keyIrqEdge));
  ppc_pin_model pins (.clock(clock), .pinOut(pinOut), .pinOe_n(pinOe_n),
    .pullupOn(pullupOn), .extEn(extEn), .extVal(extVal), .pinLevel(pinLevel));

  initial begin
    forever #10 clock = ~clock;
  end
  // ----------------------------------------
  // Closing and hang guard
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Whole run needs a few hundred cycles; the ceiling leaves ample slack
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // Bus tasks, entered just after a rising edge
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    // Request held until pready is seen high at an edge; the hang guard ends a stuck wait
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(rd, x)
  endtask
  // Pulses seen on the event outputs over a short window
  task automatic count_pulses;
    cnt = '{default: 0};
    repeat (6) begin
      @(posedge clock);
      for (int i = 0; i < 5; i++) cnt[i] += extIrqInputs[i];
      cnt[5] += keyIrqEdge;
    end
  endtask
  // Expected drive of the peripheral outputs in control mode
  function automatic void exp_alt(input ppc_alt_out_t a, output logic [21:0] po,
                                  output logic [21:0] oe);
    po = 22'h0;
    oe = 22'h3fffff;
    {po[1], oe[1]} = {a.timer16Out, ~a.timer16OutEn};
    po[2] = a.csiClockOe ? a.csiClockOut : a.uart0Tx;
    oe[2] = ~(a.csiClockOe | a.uart0TxEn);
    {po[4], oe[4]} = {a.csiDataOut, ~a.csiDataOe};
    {po[5], oe[5]} = {a.uart6Tx, ~a.uart6TxEn};
    {po[7], oe[7]} = {a.timerH0, ~a.timerH0En};
    {po[8], oe[8]} = {a.timerH1, ~a.timerH1En};
    {po[9], oe[9]} = {a.timer8aOut, ~a.timer8aOutEn};
    {po[18], oe[18]} = {a.timer8bOut, ~a.timer8bOutEn};
    {oe[19], oe[20]} = {~a.i2cSclLow, ~a.i2cSdaLow};
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = $urandom(32'hf395);
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    `CHK(pinOe_n, 22'h3fffff)
    `CHK(pullupOn, 22'h0)
    `CHK(analogEnable, 5'h1f)
    rdchk(`PPC_OFS_DIR, 32'h003fffff);
    rdchk(`PPC_OFS_PULL, 32'h0);
    rdchk(`PPC_OFS_CTRL, 32'h00007c00);
    `CHK(err, 1'b0)
    rdchk(12'h01c, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, 12'h01c, 32'hffffffff);
    `CHK(err, 1'b1)
    $display("test reset done");
    // Port mode: latch, direction and pin readback, all-out and all-in first
    apb(1'b1, `PPC_OFS_CTRL, 32'h0);
    for (int k = 0; k < 8; k++) begin
      d = (k == 0) ? 22'h0 : (k == 1) ? 22'h3fffff : 22'($urandom);
      v = $urandom;
      extEn <= d;
      extVal <= 22'($urandom);
      apb(1'b1, `PPC_OFS_OUT, {10'h0, v[21:0]});
      apb(1'b1, `PPC_OFS_DIR, {10'h0, d});
      `CHK(pinOe_n, d | (v[21:0] & 22'h180000))
      `CHK(pinOut & 22'h180000, 22'h0)
      `CHK(pinOut & ~d & 22'h27ffff, v[21:0] & ~d & 22'h27ffff)
      `CHK(altIn.timer16ClockCaptureIn, 1'b0)
      `CHK({altIn.uart0Rx, altIn.uart6Rx, altIn.i2cSclIn, altIn.i2cSdaIn, altIn.keyIrqInput}, 5'b11110)
      `CHK(analogEnable, 5'h00)
      rdchk(`PPC_OFS_OUT, {10'h0, v[21:0]});
      rdchk(`PPC_OFS_PIN, {10'h0, (d & extVal) | (~d & v[21:0])});
    end
    $display("test port mode done");
    // Pull-ups only where the port offers them, and off while driving
    apb(1'b1, `PPC_OFS_DIR, 32'h003fffff);
    extEn <= 22'h0;
    for (int k = 0; k < 4; k++) begin
      v = (k == 0) ? 32'hffffffff : $urandom;
      apb(1'b1, `PPC_OFS_PULL, v);
      `CHK(pullupOn, v[21:0] & `PPC_PULL_MASK)
    end
    apb(1'b1, `PPC_OFS_DIR, 32'h0);
    `CHK(pullupOn, 22'h0)
    apb(1'b1, `PPC_OFS_PULL, 32'h0);
    apb(1'b1, `PPC_OFS_DIR, 32'h003fffff);
    $display("test pull-up done");
    // Control mode: peripheral routing out and in
    apb(1'b1, `PPC_OFS_CTRL, 32'h003fffff);
    for (int k = 0; k < 16; k++) begin
      v = (k == 0) ? 32'hffffffff : (k == 1) ? 32'h0 : $urandom;
      exp_alt(ppc_alt_out_t'(v[19:0]), o, e);
      altOut <= ppc_alt_out_t'(v[19:0]);
      extEn <= e;
      extVal <= 22'($urandom);
      repeat (3) @(posedge clock);
      `CHK(pinOe_n, e)
      `CHK(pinOut & ~e, o & ~e)
      `CHK(analogEnable, 5'h1f)
      `CHK(altIn.timer16ClockCaptureIn, pinLevel[0])
      `CHK(altIn.uart0Rx, pinLevel[3])
      `CHK(altIn.timer8bClockIn, pinLevel[18])
      `CHK(altIn.keyIrqInput, pinLevel[21])
      `CHK(altIn.i2cSdaIn, pinLevel[20])
      `CHK({altIn.timer16CaptureIn, altIn.csiClockIn, altIn.csiDataIn, altIn.uart6Rx}, {pinLevel[1], pinLevel[2], pinLevel[3], pinLevel[6]})
      `CHK({altIn.timer8aClockIn, altIn.i2cSclIn, altIn.analogInputs}, {pinLevel[9], pinLevel[19], 5'h1f})
    end
    $display("test control mode done");
    // Event inputs under each edge selection, key input on falls only
    altOut <= '0;
    extEn <= 22'h3fffff;
    extVal <= 22'h0;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, `PPC_OFS_RISE, m[0] ? 32'h1f : 32'h0);
      apb(1'b1, `PPC_OFS_FALL, m[1] ? 32'h1f : 32'h0);
      rdchk(`PPC_OFS_RISE, m[0] ? 32'h1f : 32'h0);
      rdchk(`PPC_OFS_FALL, m[1] ? 32'h1f : 32'h0);
      for (int s = 0; s < 2; s++) begin
        extVal <= s ? 22'h0 : 22'h278100;
        count_pulses();
        for (int i = 0; i < 5; i++) `CHK(cnt[i], s ? m[1] : m[0])
        `CHK(cnt[5], s)
      end
    end
    $display("test edges done");
    // Second reset in mid-run restores the safe state
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    `CHK(pinOe_n, 22'h3fffff)
    `CHK(analogEnable, 5'h1f)
    $display("test second reset done");
    give_verdict();
  end
endmodule // tb_port_pin_control
`default_nettype wire
